// >>> rtl/buck_ctrl_pkg.sv
// Constants, register map and types for the step-down converter control.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
package buck_ctrl_pkg;

	localparam int unsigned NCONV = 3;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_PRI0 = 8'h08;
	localparam logic [7:0] ADDR_SCL0 = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h28;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h2C;

	// Control register fields
	localparam int unsigned CTRL_ON_LSB = 0;
	localparam int unsigned CTRL_QUICK_BIT = 3;
	localparam int unsigned CTRL_VS_SOFT_BIT = 4;
	localparam int unsigned CTRL_VS_PIN_EN_BIT = 5;

	// Mode register fields, one bit per converter from each LSB
	localparam int unsigned MODE_INH_LSB = 0;
	localparam int unsigned MODE_REQ_LSB = 4;
	localparam int unsigned MODE_FORCE_LSB = 8;
	localparam int unsigned MODE_FREQ_LSB = 12;

	// Status register fields
	localparam int unsigned STAT_EN_LSB = 0;
	localparam int unsigned STAT_RAMP_LSB = 3;
	localparam int unsigned STAT_XIT_LSB = 6;
	localparam int unsigned STAT_VS_BIT = 9;
	localparam int unsigned STAT_RANGE_LSB = 10;

	// Interrupt fields
	localparam int unsigned IRQ_W = 9;
	localparam int unsigned IRQ_SS_LSB = 0;
	localparam int unsigned IRQ_VS_LSB = 3;
	localparam int unsigned IRQ_OV_LSB = 6;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [7:0] SETPT_RST = 8'h40;

	// Voltage code decoding, microvolts
	localparam int unsigned TGT_W = 22;
	localparam int unsigned R1_BASE_UV = 600000;
	localparam int unsigned R1_STEP_UV = 9376;
	localparam int unsigned R2_BASE_UV = 800000;
	localparam int unsigned R2_STEP_UV = 12500;

	// Timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned SS_SLOW_US = 600;
	localparam int unsigned SS_FAST_US = 250;
	localparam int unsigned SLEW_STEP_NS = 1000;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned SS_SLOW_CYC = SS_SLOW_US * CLK_MHZ;
	localparam int unsigned SS_FAST_CYC = SS_FAST_US * CLK_MHZ;
	localparam int unsigned SLEW_CYC = SLEW_STEP_NS * CLK_MHZ / 1000;
	localparam int unsigned SLEW_W = 8;
	localparam int unsigned SYNC_W = 7;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_RAMP,
		ST_ON
	} conv_state_t;

endpackage : buck_ctrl_pkg

// >>> rtl/buck_regulator_control.sv
// Control logic for three step-down converters behind a Wishbone slave.
// Assumes factory straps are static and pin inputs are asynchronous.
//
// Summary of operation
// - Primary setpoint normally; scaled setpoint while voltage scaling active.
// - Range one, converters one and two: 0.6 V plus code times 9.376 mV.
// - Range two, all converters: 0.8 V plus code times 12.5 mV.
// - Deep light-load saving only when inhibit is 0 and request is 1.
// - Force bit 1 keeps fixed frequency; else power save at light load.
// - Soft-start 600 us when quick select is 0, 250 us when 1.
// - Soft-start on every enable and on every fault restart.
// - Force bit set to 1 during every setpoint transition, either direction.
// - Output moves between setpoints gradually at a defined slew rate after soft-start.
// - Each converter enabled or disabled by its own on bit.
// - Followers of a disabled converter follow the factory option set.
// - Disabled converter closes its discharge switch to power ground.
// - At full duty after soft-start the high-side switch is held on continuously.
// - Each converter switches at 1.125 MHz or 2.25 MHz by configuration.
// - A pin may serve as the voltage-scaling select input.
module buck_regulator_control #(
	parameter logic [15:0] SS_SLOW_CYC = 16'(buck_ctrl_pkg::SS_SLOW_CYC),
	parameter logic [15:0] SS_FAST_CYC = 16'(buck_ctrl_pkg::SS_FAST_CYC)
) (
	input wire logic ref_clk_i, // System clock
	input wire logic sys_rst_i, // Async reset, active high
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic [2:0] range_one_i, // Strap: 1 selects range one, bits 0/1 only
	input wire logic [1:0] follow_cfg_i, // Strap: conv 2/3 follow conv 1
	input wire logic vs_pin_i, // Scaling select pin
	input wire logic [2:0] fault_restart_i, // Fault restart request
	input wire logic [2:0] duty_full_i, // Full duty demanded
	output logic [2:0] conv_en_o, // Converter running
	output logic [2:0] discharge_o, // Discharge switch closed
	output logic [2:0] ramp_active_o, // Soft-start in progress
	output logic [2:0] deep_save_o, // Deep light-load saving
	output logic [2:0] fixed_freq_o, // Fixed-frequency forced
	output logic [2:0] high_freq_o, // 1: 2.25 MHz, 0: 1.125 MHz
	output logic [2:0] high_side_hold_o, // High-side held on
	output logic [2:0][21:0] target_uv_o, // Target voltage, uV
	output logic vs_busy_o, // Any setpoint transition busy
	output logic irq_o // Interrupt, active high
);

	function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_sel

	function automatic logic [21:0] code_to_uv(input logic range_one,
			input logic [7:0] code);
		int unsigned uv;
		uv = range_one ?
			buck_ctrl_pkg::R1_BASE_UV + 32'(code) * buck_ctrl_pkg::R1_STEP_UV :
			buck_ctrl_pkg::R2_BASE_UV + 32'(code) * buck_ctrl_pkg::R2_STEP_UV;
		return uv[21:0];
	endfunction : code_to_uv

	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] ctrl_q;
	logic [31:0] mode_q;
	logic [2:0] force_q;
	logic [2:0] force_save_q;
	logic [2:0][7:0] pri_q;
	logic [2:0][7:0] scl_q;
	logic [buck_ctrl_pkg::IRQ_W-1:0] irq_stat_q;
	logic [buck_ctrl_pkg::IRQ_W-1:0] irq_en_q;
	logic [2:0] range_one_q;
	logic [1:0] follow_q;
	logic strap_done_q;
	logic [buck_ctrl_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, st_q;
	logic [2:0] fault_prev_q;
	buck_ctrl_pkg::conv_state_t state_q [3];
	logic [2:0][15:0] ss_cnt_q;
	logic [2:0][7:0] cur_code_q;
	logic [2:0][7:0] slew_cnt_q;
	logic [2:0] xit_q;

	logic req;
	logic wr;
	logic vs_act;
	logic [15:0] ss_len;
	logic [2:0] en_req;
	logic [2:0] fault_pulse;
	logic [2:0] xs_start;
	logic [2:0] xs_end;
	logic [2:0] ss_done;
	logic [2:0][7:0] want_code;
	logic [buck_ctrl_pkg::IRQ_W-1:0] irq_ev;
	logic [buck_ctrl_pkg::IRQ_W-1:0] irq_clr;
	logic [31:0] rd_mux;
	logic [31:0] clr_word;
	logic [31:0] en_word;
	logic [2:0] follow_mask;

	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr = req & wb_we_i;
	assign vs_act = ctrl_q[buck_ctrl_pkg::CTRL_VS_SOFT_BIT] |
		(ctrl_q[buck_ctrl_pkg::CTRL_VS_PIN_EN_BIT] & st_q[0]);
	assign ss_len = ctrl_q[buck_ctrl_pkg::CTRL_QUICK_BIT] ?
		SS_FAST_CYC : SS_SLOW_CYC;

	assign follow_mask = {follow_q, 1'b0};
	assign clr_word = merge_sel(32'h0000_0000, wb_dat_i, wb_sel_i);
	assign en_word = merge_sel(32'(irq_en_q), wb_dat_i, wb_sel_i);

	always_comb begin
		irq_clr = '0;
		if (wr && wb_adr_i[7:2] == buck_ctrl_pkg::ADDR_IRQ_CLR[7:2]) begin
			irq_clr = clr_word[buck_ctrl_pkg::IRQ_W-1:0];
		end
	end

	// Per-converter decisions
	always_comb begin
		irq_ev = '0;
		for (int i = 0; i < 3; i++) begin
			en_req[i] = ctrl_q[buck_ctrl_pkg::CTRL_ON_LSB + i];
			if (follow_mask[i] && !ctrl_q[buck_ctrl_pkg::CTRL_ON_LSB]) begin
				en_req[i] = 1'b0;
			end
			fault_pulse[i] = st_q[1+i] & ~fault_prev_q[i];
			want_code[i] = vs_act ? scl_q[i] : pri_q[i];
			ss_done[i] = (state_q[i] == buck_ctrl_pkg::ST_RAMP) &&
				(ss_cnt_q[i] >= ss_len - 16'h0001) && !fault_pulse[i];
			xs_start[i] = (state_q[i] == buck_ctrl_pkg::ST_ON) && en_req[i] &&
				!xit_q[i] && (cur_code_q[i] != want_code[i]);
			xs_end[i] = xit_q[i] && (cur_code_q[i] == want_code[i]);
			irq_ev[buck_ctrl_pkg::IRQ_SS_LSB + i] = ss_done[i];
			irq_ev[buck_ctrl_pkg::IRQ_VS_LSB + i] = xs_end[i];
			irq_ev[buck_ctrl_pkg::IRQ_OV_LSB + i] = xs_start[i] && vs_act &&
				(pri_q[i] <= scl_q[i]);
		end
	end

	// Bus handshake, one registered answer per request, acknowledged the next cycle
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req) begin
				rdata_q <= wb_we_i ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (wb_adr_i[7:2])
			buck_ctrl_pkg::ADDR_CTRL[7:2]: rd_mux = ctrl_q;
			buck_ctrl_pkg::ADDR_MODE[7:2]: begin
				rd_mux = mode_q;
				rd_mux[buck_ctrl_pkg::MODE_FORCE_LSB +: 3] = force_q;
			end
			buck_ctrl_pkg::ADDR_STAT[7:2]: begin
				for (int i = 0; i < 3; i++) begin
					rd_mux[buck_ctrl_pkg::STAT_EN_LSB + i] =
						state_q[i] != buck_ctrl_pkg::ST_OFF;
					rd_mux[buck_ctrl_pkg::STAT_RAMP_LSB + i] =
						state_q[i] == buck_ctrl_pkg::ST_RAMP;
				end
				rd_mux[buck_ctrl_pkg::STAT_XIT_LSB +: 3] = xit_q;
				rd_mux[buck_ctrl_pkg::STAT_VS_BIT] = vs_act;
				rd_mux[buck_ctrl_pkg::STAT_RANGE_LSB +: 3] = range_one_q;
			end
			buck_ctrl_pkg::ADDR_IRQ_STAT[7:2]:
				rd_mux[buck_ctrl_pkg::IRQ_W-1:0] = irq_stat_q;
			buck_ctrl_pkg::ADDR_IRQ_EN[7:2]:
				rd_mux[buck_ctrl_pkg::IRQ_W-1:0] = irq_en_q;
			default: begin
				for (int i = 0; i < 3; i++) begin
					if (wb_adr_i[7:2] == 6'(buck_ctrl_pkg::ADDR_PRI0[7:2] + i)) begin
						rd_mux[7:0] = pri_q[i];
					end
					if (wb_adr_i[7:2] == 6'(buck_ctrl_pkg::ADDR_SCL0[7:2] + i)) begin
						rd_mux[7:0] = scl_q[i];
					end
				end
			end
		endcase
	end

	// Software registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q <= buck_ctrl_pkg::CTRL_RST;
			mode_q <= buck_ctrl_pkg::MODE_RST;
			irq_en_q <= '0;
			pri_q <= {3{buck_ctrl_pkg::SETPT_RST}};
			scl_q <= {3{buck_ctrl_pkg::SETPT_RST}};
		end else if (wr) begin
			if (wb_adr_i[7:2] == buck_ctrl_pkg::ADDR_CTRL[7:2]) begin
				ctrl_q <= merge_sel(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_003F;
			end
			if (wb_adr_i[7:2] == buck_ctrl_pkg::ADDR_MODE[7:2]) begin
				mode_q <= merge_sel(mode_q, wb_dat_i, wb_sel_i) & 32'h0000_7077;
			end
			if (wb_adr_i[7:2] == buck_ctrl_pkg::ADDR_IRQ_EN[7:2]) begin
				irq_en_q <= en_word[buck_ctrl_pkg::IRQ_W-1:0];
			end
			for (int i = 0; i < 3; i++) begin
				if (wb_sel_i[0] &&
						wb_adr_i[7:2] == 6'(buck_ctrl_pkg::ADDR_PRI0[7:2] + i)) begin
					pri_q[i] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[0] &&
						wb_adr_i[7:2] == 6'(buck_ctrl_pkg::ADDR_SCL0[7:2] + i)) begin
					scl_q[i] <= wb_dat_i[7:0];
				end
			end
		end
	end

	// Force bit: software value, overridden while a transition runs
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			force_q <= '0;
			force_save_q <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (xs_start[i]) begin
					force_save_q[i] <= force_q[i];
					force_q[i] <= 1'b1;
				end else if (xs_end[i] || (xit_q[i] &&
						(state_q[i] != buck_ctrl_pkg::ST_ON || !en_req[i]))) begin
					// An aborted transition gives back the saved value too
					force_q[i] <= force_save_q[i];
				end else if (wr && wb_sel_i[1] &&
						wb_adr_i[7:2] == buck_ctrl_pkg::ADDR_MODE[7:2]) begin
					if (xit_q[i]) begin
						force_save_q[i] <= wb_dat_i[buck_ctrl_pkg::MODE_FORCE_LSB + i];
					end else begin
						force_q[i] <= wb_dat_i[buck_ctrl_pkg::MODE_FORCE_LSB + i];
					end
				end
			end
		end
	end

	// Sticky interrupt status, set wins over clear
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
		end
	end

	// Straps caught once after reset release
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_done_q <= 1'b0;
			range_one_q <= '0;
			follow_q <= '0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			range_one_q <= {1'b0, range_one_i[1:0]};
			follow_q <= follow_cfg_i;
		end
	end

	// Pin synchronisers: value accepted when stages two and three agree
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			st_q <= '0;
			fault_prev_q <= '0;
		end else begin
			s1_q <= {duty_full_i, fault_restart_i, vs_pin_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int b = 0; b < buck_ctrl_pkg::SYNC_W; b++) begin
				if (s2_q[b] == s3_q[b]) begin
					st_q[b] <= s3_q[b];
				end
			end
			fault_prev_q <= st_q[3:1];
		end
	end

	// Converter sequencing: off, soft-start ramp, on
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 3; i++) begin
				state_q[i] <= buck_ctrl_pkg::ST_OFF;
			end
			ss_cnt_q <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				unique case (state_q[i])
					buck_ctrl_pkg::ST_OFF: begin
						ss_cnt_q[i] <= '0;
						if (en_req[i] && strap_done_q) begin
							state_q[i] <= buck_ctrl_pkg::ST_RAMP;
						end
					end
					buck_ctrl_pkg::ST_RAMP: begin
						ss_cnt_q[i] <= ss_cnt_q[i] + 16'h0001;
						if (!en_req[i]) begin
							state_q[i] <= buck_ctrl_pkg::ST_OFF;
						end else if (fault_pulse[i]) begin
							ss_cnt_q[i] <= '0;
						end else if (ss_done[i]) begin
							state_q[i] <= buck_ctrl_pkg::ST_ON;
						end
					end
					buck_ctrl_pkg::ST_ON: begin
						ss_cnt_q[i] <= '0;
						if (!en_req[i]) begin
							state_q[i] <= buck_ctrl_pkg::ST_OFF;
						end else if (fault_pulse[i]) begin
							state_q[i] <= buck_ctrl_pkg::ST_RAMP;
						end
					end
				endcase
			end
		end
	end

	// Setpoint slew: one code step per slew interval
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cur_code_q <= {3{buck_ctrl_pkg::SETPT_RST}};
			slew_cnt_q <= '0;
			xit_q <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (state_q[i] != buck_ctrl_pkg::ST_ON || !en_req[i]) begin
					cur_code_q[i] <= want_code[i];
					slew_cnt_q[i] <= '0;
					xit_q[i] <= 1'b0;
				end else if (xs_start[i]) begin
					xit_q[i] <= 1'b1;
					slew_cnt_q[i] <= '0;
				end else if (xs_end[i]) begin
					xit_q[i] <= 1'b0;
				end else if (xit_q[i]) begin
					if (slew_cnt_q[i] == 8'(buck_ctrl_pkg::SLEW_CYC - 1)) begin
						slew_cnt_q[i] <= '0;
						cur_code_q[i] <= (cur_code_q[i] < want_code[i]) ?
							cur_code_q[i] + 8'h01 :
							cur_code_q[i] - 8'h01;
					end else begin
						slew_cnt_q[i] <= slew_cnt_q[i] + 8'h01;
					end
				end
			end
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			conv_en_o <= '0;
			discharge_o <= '1;
			ramp_active_o <= '0;
			deep_save_o <= '0;
			fixed_freq_o <= '0;
			high_freq_o <= '0;
			high_side_hold_o <= '0;
			target_uv_o <= '0;
			vs_busy_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				conv_en_o[i] <= state_q[i] != buck_ctrl_pkg::ST_OFF;
				// Closes the 4.4/9.4 ohm path whenever the converter is off
				discharge_o[i] <= state_q[i] == buck_ctrl_pkg::ST_OFF;
				ramp_active_o[i] <= state_q[i] == buck_ctrl_pkg::ST_RAMP;
				deep_save_o[i] <= state_q[i] != buck_ctrl_pkg::ST_OFF &&
					!mode_q[buck_ctrl_pkg::MODE_INH_LSB + i] &&
					mode_q[buck_ctrl_pkg::MODE_REQ_LSB + i];
				fixed_freq_o[i] <= force_q[i];
				high_freq_o[i] <= mode_q[buck_ctrl_pkg::MODE_FREQ_LSB + i];
				high_side_hold_o[i] <= state_q[i] == buck_ctrl_pkg::ST_ON &&
					st_q[4+i];
				target_uv_o[i] <= code_to_uv(range_one_q[i],
					cur_code_q[i]);
			end
			vs_busy_o <= |xit_q;
			irq_o <= |(irq_stat_q & irq_en_q);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

endmodule : buck_regulator_control

// >>> verif/buck_regulator_control_monitor.sv
// Checker of bus handshake and converter output relations.
// Assumes binding to the control block, ramp counts passed as parameters.
module buck_regulator_control_monitor #(
	parameter logic [15:0] SS_SLOW_CYC = 16'hEA60,
	parameter logic [15:0] SS_FAST_CYC = 16'h61A8
) (
	input wire logic ref_clk_i, // Clock
	input wire logic sys_rst_i, // Reset
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_ack_o, // Acknowledge
	input wire logic [2:0] conv_en_o, // Running
	input wire logic [2:0] discharge_o, // Discharge
	input wire logic [2:0] ramp_active_o, // Soft-start
	input wire logic [2:0] deep_save_o, // Deep saving
	input wire logic [2:0] fixed_freq_o, // Forced
	input wire logic [2:0] high_side_hold_o, // Held on
	input wire logic [2:0][21:0] target_uv_o, // Target
	input wire logic vs_busy_o // Transition busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic [15:0] ramp_cnt_q;
	// Length of the current soft-start of converter one
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ramp_cnt_q <= 16'h0000;
		end else if (ramp_active_o[0]) begin
			ramp_cnt_q <= ramp_cnt_q + 16'h0001;
		end else begin
			ramp_cnt_q <= 16'h0000;
		end
	end
	chk_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	chk_discharge_off: assert property (
		discharge_o == ~conv_en_o)
		else $error("discharge not opposite to enable");
	chk_ramp_on: assert property (
		(ramp_active_o & ~conv_en_o) == 3'b000)
		else $error("ramp on a stopped converter");
	chk_save_gate: assert property (
		(deep_save_o & ~conv_en_o) == 3'b000)
		else $error("deep saving on a stopped converter");
	chk_hold_on: assert property (
		(high_side_hold_o & (~conv_en_o | ramp_active_o)) == 3'b000)
		else $error("high side held outside on state");
	chk_busy_force: assert property (
		vs_busy_o |-> fixed_freq_o != 3'b000)
		else $error("transition without forced frequency");
	chk_ramp_len: assert property (
		$fell(ramp_active_o[0]) && conv_en_o[0] |->
		(ramp_cnt_q == SS_SLOW_CYC || ramp_cnt_q == SS_FAST_CYC))
		else $error("soft-start length wrong");
	chk_slew_gap: assert property (
		vs_busy_o && $changed(target_uv_o[0]) |=>
		$stable(target_uv_o[0]) [*8])
		else $error("target stepped too fast");
endmodule : buck_regulator_control_monitor

bind buck_regulator_control buck_regulator_control_monitor #(
	.SS_SLOW_CYC(SS_SLOW_CYC),
	.SS_FAST_CYC(SS_FAST_CYC)
) i_mon (
	.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.conv_en_o(conv_en_o),
	.discharge_o(discharge_o),
	.ramp_active_o(ramp_active_o),
	.deep_save_o(deep_save_o),
	.fixed_freq_o(fixed_freq_o),
	.high_side_hold_o(high_side_hold_o),
	.target_uv_o(target_uv_o),
	.vs_busy_o(vs_busy_o)
);

// >>> verif/buck_regulator_control_tb.sv
// Self-checking bench for the converter control block.
// Assumes the package is compiled first; ramps use short parameters.
module buck_regulator_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] SLOW = 16'h0028;
	localparam logic [15:0] FAST = 16'h0014;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic vs_pin_i = 1'b0;
	logic [2:0] fault_restart_i = 3'b000;
	logic [2:0] duty_full_i = 3'b000;
	logic [1:0] follow_cfg = 2'b00;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic wb_ack_o;
	logic vs_busy_o;
	logic irq_o;
	logic [2:0] conv_en_o;
	logic [2:0] discharge_o;
	logic [2:0] ramp_active_o;
	logic [2:0] deep_save_o;
	logic [2:0] fixed_freq_o;
	logic [2:0] high_freq_o;
	logic [2:0] high_side_hold_o;
	logic [2:0][21:0] target_uv_o;
	int errors = 0;
	int checked = 0;
	int n = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	buck_regulator_control #(.SS_SLOW_CYC(SLOW), .SS_FAST_CYC(FAST)) i_dut (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.range_one_i(3'b011),
		.follow_cfg_i(follow_cfg),
		.vs_pin_i(vs_pin_i),
		.fault_restart_i(fault_restart_i),
		.duty_full_i(duty_full_i),
		.conv_en_o(conv_en_o),
		.discharge_o(discharge_o),
		.ramp_active_o(ramp_active_o),
		.deep_save_o(deep_save_o),
		.fixed_freq_o(fixed_freq_o),
		.high_freq_o(high_freq_o),
		.high_side_hold_o(high_side_hold_o),
		.target_uv_o(target_uv_o),
		.vs_busy_o(vs_busy_o),
		.irq_o(irq_o)
	);
	function automatic logic [31:0] uv(input logic r1, input int c);
		return r1 ? buck_ctrl_pkg::R1_BASE_UV + c * buck_ctrl_pkg::R1_STEP_UV
			: buck_ctrl_pkg::R2_BASE_UV + c * buck_ctrl_pkg::R2_STEP_UV;
	endfunction : uv
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge ref_clk_i);
			n++;
		end
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb_io(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		n = 0;
		tick(1);
		while (wb_ack_o !== 1'b1 && n < 50) tick(1);
		if (n >= 50) errors++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_io
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb_io(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rchk
	task automatic ramp_len(input logic [15:0] exp);
		n = 0;
		while (ramp_active_o[0] !== 1'b1 && n < 20) tick(1);
		n = 0;
		while (ramp_active_o[0] === 1'b1 && n < 100) tick(1);
		chk(32'(n), 32'(exp));
	endtask : ramp_len
	task automatic t_reset;
		tick(2);
		chk(32'(discharge_o), 32'h0000_0007);
		rchk(buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0000);
		rchk(buck_ctrl_pkg::ADDR_MODE, 32'h0000_0000);
		rchk(buck_ctrl_pkg::ADDR_PRI0, 32'h0000_0040);
		rchk(buck_ctrl_pkg::ADDR_STAT, 32'h0000_0C00);
		rchk(8'h30, 32'h0000_0000);
		rchk(buck_ctrl_pkg::ADDR_IRQ_CLR, 32'h0000_0000);
		chk(32'(target_uv_o[0]), uv(1'b1, 64));
		chk(32'(target_uv_o[2]), uv(1'b0, 64));
	endtask : t_reset
	task automatic t_decode;
		wb_io(1'b1, buck_ctrl_pkg::ADDR_PRI0, 32'h0000_005F);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_PRI0 + 8'h08, 32'h0000_005F);
		tick(3);
		chk(32'(target_uv_o[0]), uv(1'b1, 95));
		chk(32'(target_uv_o[2]), uv(1'b0, 95));
		wb_io(1'b1, buck_ctrl_pkg::ADDR_PRI0, 32'h0000_0048);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_SCL0, 32'h0000_0046);
		tick(3);
		chk(32'(target_uv_o[0]), uv(1'b1, 72));
	endtask : t_decode
	task automatic t_enable;
		wb_io(1'b1, buck_ctrl_pkg::ADDR_IRQ_EN, 32'h0000_01FF);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0009);
		ramp_len(FAST);
		tick(2);
		chk(32'(conv_en_o), 32'h0000_0001);
		chk(32'(discharge_o), 32'h0000_0006);
		chk(32'(irq_o), 32'h0000_0001);
		rchk(buck_ctrl_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_IRQ_EN, 32'h0000_0000);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0001);
		tick(2);
		chk(32'(irq_o), 32'h0000_0000);
		fault_restart_i <= 3'b001;
		ramp_len(SLOW);
		fault_restart_i <= 3'b000;
		tick(2);
		chk(32'(irq_o), 32'h0000_0000);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_IRQ_EN, 32'h0000_01FF);
		tick(2);
		chk(32'(irq_o), 32'h0000_0001);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_IRQ_CLR, 32'h0000_01FF);
		tick(2);
		chk(32'(irq_o), 32'h0000_0000);
	endtask : t_enable
	task automatic t_mode;
		wb_io(1'b1, buck_ctrl_pkg::ADDR_MODE, 32'h0000_1110);
		tick(3);
		chk(32'(deep_save_o), 32'h0000_0001);
		chk(32'(fixed_freq_o), 32'h0000_0001);
		chk(32'(high_freq_o), 32'h0000_0001);
		rchk(buck_ctrl_pkg::ADDR_MODE, 32'h0000_1110);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_MODE, 32'h0000_0011);
		tick(3);
		chk(32'({deep_save_o, fixed_freq_o, high_freq_o}), 32'h0000_0000);
		duty_full_i <= 3'b001;
		tick(8);
		chk(32'(high_side_hold_o), 32'h0000_0001);
		duty_full_i <= 3'b000;
		tick(8);
		chk(32'(high_side_hold_o), 32'h0000_0000);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_MODE, 32'h0000_0000);
	endtask : t_mode
	task automatic dvs_run(input int c_end);
		n = 0;
		while (vs_busy_o !== 1'b1 && n < 20) tick(1);
		chk(32'(vs_busy_o), 32'h0000_0001);
		tick(1);
		chk(32'(fixed_freq_o[0]), 32'h0000_0001);
		tick(150);
		chk(32'(target_uv_o[0]), uv(1'b1, 71));
		n = 0;
		while (vs_busy_o === 1'b1 && n < 400) tick(1);
		tick(2);
		chk(32'(target_uv_o[0]), uv(1'b1, c_end));
		chk(32'(fixed_freq_o[0]), 32'h0000_0000);
	endtask : dvs_run
	task automatic t_dvs;
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0011);
		dvs_run(70);
		rchk(buck_ctrl_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
		vs_pin_i <= 1'b1;
		tick(8);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0021);
		tick(8);
		vs_pin_i <= 1'b0;
		dvs_run(72);
	endtask : t_dvs
	task automatic t_follow;
		sys_rst_i <= 1'b1;
		follow_cfg <= 2'b01;
		tick(2);
		sys_rst_i <= 1'b0;
		tick(2);
		chk(32'({conv_en_o, discharge_o}), 32'h0000_0007);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0003);
		ramp_len(SLOW);
		tick(2);
		chk(32'(conv_en_o), 32'h0000_0003);
		chk(32'(target_uv_o[1]), uv(1'b1, 64));
		wb_io(1'b1, buck_ctrl_pkg::ADDR_SCL0, 32'h0000_0041);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0013);
		rchk(buck_ctrl_pkg::ADDR_IRQ_STAT, 32'h0000_0043);
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0002);
		tick(3);
		chk(32'(conv_en_o), 32'h0000_0000);
		chk(32'(fixed_freq_o), 32'h0000_0000);
	endtask : t_follow
	task automatic t_off;
		wb_io(1'b1, buck_ctrl_pkg::ADDR_CTRL, 32'h0000_0000);
		tick(3);
		chk(32'(conv_en_o), 32'h0000_0000);
		chk(32'(discharge_o), 32'h0000_0007);
	endtask : t_off
	task automatic conclude;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		errors++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_decode();
		t_enable();
		t_mode();
		t_dvs();
		t_follow();
		t_off();
		conclude();
	end
endmodule : buck_regulator_control_tb
